// [core/fci_pkg.sv]
// Purpose: Shared constants and types for the nonvolatile memory command interface.
// Assumes: Avalon-MM byte-addressed register bus with 32-bit data, 10 MHz bus clock.
// Notes:   Register offsets are byte addresses, one aligned word per register.
package fci_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FCI_OFF_DIV    = 8'h00;
  localparam logic [7:0] FCI_OFF_OPT    = 8'h04;
  localparam logic [7:0] FCI_OFF_TST    = 8'h08;
  localparam logic [7:0] FCI_OFF_CFG    = 8'h0C;
  localparam logic [7:0] FCI_OFF_PROT   = 8'h10;
  localparam logic [7:0] FCI_OFF_STAT   = 8'h14;
  localparam logic [7:0] FCI_OFF_CMD    = 8'h18;
  localparam logic [7:0] FCI_OFF_ADDR   = 8'h1C;
  localparam logic [7:0] FCI_OFF_DATA   = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCI_B_DIVIDER_LOADED_FLAG  = 7;
  localparam int FCI_B_PRDIV  = 6;
  localparam int FCI_B_MAPMOD = 5;
  localparam int FCI_B_PGSEL  = 6;
  localparam int FCI_B_CBEF   = 7;
  localparam int FCI_B_CCF    = 6;
  localparam int FCI_B_PVIOL  = 5;
  localparam int FCI_B_ACCERR = 4;
  localparam int FCI_B_BLANK  = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FCI_RST_STAT = 8'hC0;
  localparam logic [7:0] FCI_RST_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] FCI_FL_LO_BEG = 16'h1080;
  localparam logic [15:0] FCI_FL_LO_END = 16'h13FF;
  localparam logic [15:0] FCI_FL_HI_BEG = 16'h1900;
  localparam logic [15:0] FCI_FL_HI_END = 16'hFFFF;
  localparam logic [15:0] FCI_EE_BEG    = 16'h0800;
  localparam logic [15:0] FCI_EE_END    = 16'h0BFF;
  localparam int          FCI_FL_SECTOR = 768;
  localparam int          FCI_EE_SECTOR = 8;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FCI_CMD_BLANK = 8'h05;
  localparam logic [7:0] FCI_CMD_PROG  = 8'h20;
  localparam logic [7:0] FCI_CMD_BURST = 8'h25;
  localparam logic [7:0] FCI_CMD_SERA  = 8'h40;
  localparam logic [7:0] FCI_CMD_MERA  = 8'h41;

  // ----------------------------------------------------------------
  // Timing, in ticks of the divided memory clock
  // ----------------------------------------------------------------
  localparam int FCI_PROG_US     = 20;
  localparam int FCI_NVM_KHZ     = 200;
  localparam int FCI_PROG_TICKS  = (FCI_PROG_US * FCI_NVM_KHZ + 999) / 1000;
  localparam int FCI_BURST_TICKS = FCI_PROG_TICKS / 2;
  localparam int FCI_SERA_TICKS  = 4000;
  localparam int FCI_MERA_TICKS  = 4000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } fci_req_t;

  typedef enum logic [4:0] {
    FCI_IDLE  = 5'b00001,
    FCI_ARMED = 5'b00010,
    FCI_RUN   = 5'b00100,
    FCI_CHECK = 5'b01000,
    FCI_DONE  = 5'b10000
  } fci_state_t;

endpackage : fci_pkg

// [core/fci_top.sv]
// Purpose: Command interface that programs, erases and blank-checks a flash array and a paged EEPROM.
// Assumes: One 10 MHz clock, asynchronous active-low reset, Avalon-MM slave with waitrequest.
// Notes:   The arrays are abstracted as an enable/address/data port towards the memory macro.
//
// Summary of operation
// - Flash decodes as one array across a low window and an upper window to top.
// - Each program command writes exactly one byte location.
// - Burst program runs sequential bytes with shorter per-byte time than single program.
// - Flash erases by one 768-byte sector or by mass erase.
// - Program, erase and blank check all go through one command interface.
// - Software loads the divider; all program and erase timing comes from divided clock.
// - A single flash byte program takes about twenty microseconds.
// - Blank check verifies the whole array is erased and reports it in a flag.
// - Steps out of order set the access-error flag.
// - EEPROM is two 1024-byte halves sharing one window, one half mapped.
// - Page select chooses the visible EEPROM half; the other half is reached only by mass erase or by split-mapping sector erase.
// - Mapping bit 0 splits each 8-byte sector into four foreground, four background bytes.
// - In split mapping a sector erase clears all eight bytes of both halves.
// - Mapping bit 1 keeps each 8-byte sector wholly within one page.
// - In whole-sector mapping a sector erase clears only the foreground sector.
// - EEPROM programs one byte per operation and also offers burst programming.
// - EEPROM supports mass erase and eight-byte sector erase in either mapping.
// - Flash and EEPROM share one interface and are never programmed concurrently.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module fci_top #(
  parameter int ERASE_TICKS = fci_pkg::FCI_SERA_TICKS,
  parameter int BLANK_WORDS = 64
) (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             avs_response_err_out,
  input  wire logic        mem_erased_in,
  output logic             mem_en_out,
  output logic             mem_eeprom_out,
  output logic             mem_erase_out,
  output logic      [16:0] mem_addr_out,
  output logic      [7:0]  mem_data_out,
  output logic      [16:0] mem_span_out
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  fci_pkg::fci_req_t   req;
  fci_pkg::fci_state_t state_q;
  logic [7:0]  div_q;
  logic [7:0]  opt_q;
  logic [7:0]  tst_q;
  logic [7:0]  cfg_q;
  logic [7:0]  prot_q;
  logic [7:0]  cmd_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic        cbef_q;
  logic        ccf_q;
  logic        pviol_q;
  logic        accerr_q;
  logic        blank_q;
  logic [6:0]  pre_q;
  logic        tick_q;
  logic [15:0] tmr_q;
  logic [15:0] chk_q;
  logic        burst_prev_q;
  logic [15:0] last_addr_q;

  // Bus request bundle.
  assign req = '{rd: avs_read_in, wr: avs_write_in, addr: avs_address_in, wdata: avs_writedata_in};

  // Decode helpers.
  logic        sel_write;
  logic        is_flash;
  logic        is_eeprom;
  logic        is_prot;
  logic        is_prog;
  logic        is_erase;
  logic        cmd_valid;
  logic        launch;
  logic [15:0] run_ticks;
  logic [15:0] prot_top;

  assign sel_write = req.wr && avs_waitrequest_out && avs_byteenable_in[0];
  // Flash decodes as two windows of one array.
  assign is_flash  = (addr_q >= fci_pkg::FCI_FL_LO_BEG && addr_q <= fci_pkg::FCI_FL_LO_END) ||
                     (addr_q >= fci_pkg::FCI_FL_HI_BEG);
  assign is_eeprom = addr_q >= fci_pkg::FCI_EE_BEG && addr_q <= fci_pkg::FCI_EE_END;
  // Protection covers the top of flash in 512-byte steps; zero protects nothing.
  assign prot_top  = 16'hFFFF - {prot_q[4:0], 9'h000} + 16'h0001;
  assign is_prog   = cmd_q == fci_pkg::FCI_CMD_PROG || cmd_q == fci_pkg::FCI_CMD_BURST;
  assign is_erase  = cmd_q == fci_pkg::FCI_CMD_SERA || cmd_q == fci_pkg::FCI_CMD_MERA;
  assign is_prot   = (is_prog || is_erase) && is_flash && prot_q[4:0] != 5'h00 &&
                     addr_q >= prot_top;
  assign cmd_valid = is_prog || is_erase || cmd_q == fci_pkg::FCI_CMD_BLANK;
  assign launch    = sel_write && req.addr == fci_pkg::FCI_OFF_STAT && req.wdata[fci_pkg::FCI_B_CBEF] &&
                     cbef_q == 1'b0 && state_q == fci_pkg::FCI_ARMED;

  // Ticks per command: burst continues faster when the next address follows on.
  always_comb
  begin
    run_ticks = 16'(fci_pkg::FCI_PROG_TICKS);
    if (cmd_q == fci_pkg::FCI_CMD_BURST && burst_prev_q && addr_q == last_addr_q + 16'h0001)
      run_ticks = 16'(fci_pkg::FCI_BURST_TICKS);
    else if (is_erase)
      run_ticks = 16'(ERASE_TICKS);
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait state, then acknowledge.
  // ----------------------------------------------------------------
  // Waitrequest drops in the cycle the access completes; a high waitrequest marks a request not yet taken.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !((req.rd || req.wr) && avs_waitrequest_out);
  end

  // Read data mux; unmapped offsets read zero and flag an error response.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      avs_readdata_out     <= 32'h0000_0000;
      avs_response_err_out <= 1'b0;
    end
    else
    begin
      avs_response_err_out <= 1'b0;
      avs_readdata_out     <= 32'h0000_0000;
      case (req.addr)
        fci_pkg::FCI_OFF_DIV:  avs_readdata_out[7:0] <= div_q;
        fci_pkg::FCI_OFF_OPT:  avs_readdata_out[7:0] <= opt_q;
        fci_pkg::FCI_OFF_TST:  avs_readdata_out[7:0] <= tst_q;
        fci_pkg::FCI_OFF_CFG:  avs_readdata_out[7:0] <= cfg_q;
        fci_pkg::FCI_OFF_PROT: avs_readdata_out[7:0] <= prot_q;
        fci_pkg::FCI_OFF_STAT: avs_readdata_out[7:0] <= {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};
        fci_pkg::FCI_OFF_CMD:  avs_readdata_out[7:0] <= cmd_q;
        fci_pkg::FCI_OFF_ADDR: avs_readdata_out[15:0] <= addr_q;
        fci_pkg::FCI_OFF_DATA: avs_readdata_out[7:0] <= data_q;
        default:               avs_response_err_out <= (req.rd || req.wr) && avs_waitrequest_out;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Divider is write-once after reset; the loaded bit reports it.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      div_q <= fci_pkg::FCI_RST_ZERO;
    else if (sel_write && req.addr == fci_pkg::FCI_OFF_DIV && !div_q[fci_pkg::FCI_B_DIVIDER_LOADED_FLAG])
      div_q <= {1'b1, req.wdata[6:0]};
  end

  // Options: mapping mode is software-set here, other bits read-only zero.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      opt_q  <= fci_pkg::FCI_RST_ZERO;
      tst_q  <= fci_pkg::FCI_RST_ZERO;
      cfg_q  <= fci_pkg::FCI_RST_ZERO;
      prot_q <= fci_pkg::FCI_RST_ZERO;
    end
    else if (sel_write)
    begin
      if (req.addr == fci_pkg::FCI_OFF_OPT)
        opt_q[fci_pkg::FCI_B_MAPMOD] <= req.wdata[fci_pkg::FCI_B_MAPMOD];
      if (req.addr == fci_pkg::FCI_OFF_TST)
        tst_q <= req.wdata[7:0] & 8'h60;
      if (req.addr == fci_pkg::FCI_OFF_CFG)
        cfg_q <= req.wdata[7:0] & 8'h70;
      if (req.addr == fci_pkg::FCI_OFF_PROT)
        prot_q <= req.wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Divided memory clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pre_q  <= 7'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (pre_q == 7'h00)
      begin
        pre_q  <= div_q[5:0] + (div_q[fci_pkg::FCI_B_PRDIV] ? 7'h07 : 7'h00);
        tick_q <= 1'b1;
      end
      else
        pre_q <= pre_q - 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q      <= fci_pkg::FCI_IDLE;
      addr_q       <= 16'h0000;
      data_q       <= 8'h00;
      cmd_q        <= 8'h00;
      tmr_q        <= 16'h0000;
      chk_q        <= 16'h0000;
      burst_prev_q <= 1'b0;
      last_addr_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        fci_pkg::FCI_IDLE, fci_pkg::FCI_ARMED:
        begin
          // Address and data writes latch the operands; the command write arms the sequence.
          if (sel_write && req.addr == fci_pkg::FCI_OFF_ADDR && state_q == fci_pkg::FCI_IDLE)
            addr_q <= req.wdata[15:0];
          if (sel_write && req.addr == fci_pkg::FCI_OFF_DATA && state_q == fci_pkg::FCI_IDLE)
            data_q <= req.wdata[7:0];
          if (sel_write && req.addr == fci_pkg::FCI_OFF_CMD && state_q == fci_pkg::FCI_IDLE)
          begin
            cmd_q   <= req.wdata[7:0];
            state_q <= fci_pkg::FCI_ARMED;
          end
          if (launch && div_q[fci_pkg::FCI_B_DIVIDER_LOADED_FLAG] && cmd_valid && !is_prot &&
              (is_flash || is_eeprom || cmd_q != fci_pkg::FCI_CMD_PROG))
          begin
            tmr_q   <= run_ticks;
            chk_q   <= 16'(BLANK_WORDS);
            state_q <= (cmd_q == fci_pkg::FCI_CMD_BLANK) ? fci_pkg::FCI_CHECK : fci_pkg::FCI_RUN;
          end
          else if (launch)
            state_q <= fci_pkg::FCI_IDLE;
        end
        fci_pkg::FCI_RUN:
        begin
          if (tick_q)
            tmr_q <= tmr_q - 16'h0001;
          if (tick_q && tmr_q == 16'h0001)
          begin
            burst_prev_q <= cmd_q == fci_pkg::FCI_CMD_BURST;
            last_addr_q  <= addr_q;
            state_q      <= fci_pkg::FCI_DONE;
          end
        end
        fci_pkg::FCI_CHECK:
        begin
          // One location group checked per bus cycle across the array.
          chk_q <= chk_q - 16'h0001;
          if (chk_q == 16'h0001 || !mem_erased_in)
            state_q <= fci_pkg::FCI_DONE;
        end
        fci_pkg::FCI_DONE:
        begin
          if (cmd_q != fci_pkg::FCI_CMD_BURST)
            burst_prev_q <= 1'b0;
          state_q <= fci_pkg::FCI_IDLE;
        end
        default:
          state_q <= fci_pkg::FCI_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags; hardware sets win over software clears.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cbef_q   <= fci_pkg::FCI_RST_STAT[fci_pkg::FCI_B_CBEF];
      ccf_q    <= fci_pkg::FCI_RST_STAT[fci_pkg::FCI_B_CCF];
      pviol_q  <= 1'b0;
      accerr_q <= 1'b0;
      blank_q  <= 1'b0;
    end
    else
    begin
      // The command write clears the buffer-empty flag; writing one to it launches, and it stays low until done or refused.
      if (sel_write && req.addr == fci_pkg::FCI_OFF_STAT)
      begin
        if (req.wdata[fci_pkg::FCI_B_PVIOL])
          pviol_q <= 1'b0;
        if (req.wdata[fci_pkg::FCI_B_ACCERR])
          accerr_q <= 1'b0;
      end
      if (sel_write && req.addr == fci_pkg::FCI_OFF_CMD && state_q == fci_pkg::FCI_IDLE)
        cbef_q <= 1'b0;
      // Steps out of order: address, data or command write after a command, or launch without a command.
      if (sel_write && state_q != fci_pkg::FCI_IDLE &&
          (req.addr == fci_pkg::FCI_OFF_ADDR || req.addr == fci_pkg::FCI_OFF_DATA ||
           req.addr == fci_pkg::FCI_OFF_CMD))
        accerr_q <= 1'b1;
      if (sel_write && req.addr == fci_pkg::FCI_OFF_STAT && req.wdata[fci_pkg::FCI_B_CBEF] &&
          state_q == fci_pkg::FCI_IDLE)
        accerr_q <= 1'b1;
      if (launch)
      begin
        if (!div_q[fci_pkg::FCI_B_DIVIDER_LOADED_FLAG] || !cmd_valid ||
            (!is_flash && !is_eeprom && cmd_q == fci_pkg::FCI_CMD_PROG))
        begin
          accerr_q <= 1'b1;
          cbef_q   <= 1'b1;
        end
        else if (is_prot)
        begin
          pviol_q <= 1'b1;
          cbef_q  <= 1'b1;
        end
        else
        begin
          ccf_q   <= 1'b0;
          blank_q <= 1'b0;
        end
      end
      if (state_q == fci_pkg::FCI_CHECK && (chk_q == 16'h0001 || !mem_erased_in))
        blank_q <= mem_erased_in;
      if (state_q == fci_pkg::FCI_DONE)
      begin
        ccf_q  <= 1'b1;
        cbef_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory macro strobes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mem_en_out     <= 1'b0;
      mem_eeprom_out <= 1'b0;
      mem_erase_out  <= 1'b0;
      mem_addr_out   <= 17'h00000;
      mem_data_out   <= 8'h00;
      mem_span_out   <= 17'h00000;
    end
    else
    begin
      // Only one array at a time is ever driven.
      mem_en_out     <= state_q == fci_pkg::FCI_RUN || state_q == fci_pkg::FCI_CHECK;
      mem_eeprom_out <= is_eeprom;
      mem_erase_out  <= is_erase;
      mem_data_out   <= data_q;
      mem_span_out   <= 17'h00001;
      // EEPROM physical address carries the page bit, whose place depends on the mapping mode.
      if (is_eeprom)
      begin
        if (opt_q[fci_pkg::FCI_B_MAPMOD])
          mem_addr_out <= {6'h00, cfg_q[fci_pkg::FCI_B_PGSEL], addr_q[9:0]};
        else
          mem_addr_out <= {6'h00, addr_q[9:2], cfg_q[fci_pkg::FCI_B_PGSEL], addr_q[1:0]};
      end
      else
        mem_addr_out <= {1'b0, addr_q};
      if (cmd_q == fci_pkg::FCI_CMD_SERA && is_eeprom)
      begin
        if (opt_q[fci_pkg::FCI_B_MAPMOD])
        begin
          mem_addr_out <= {6'h00, cfg_q[fci_pkg::FCI_B_PGSEL], addr_q[9:3], 3'h0};
          mem_span_out <= 17'(fci_pkg::FCI_EE_SECTOR);
        end
        else
        begin
          mem_addr_out <= {6'h00, addr_q[9:2], 3'h0} & 17'h1FFF8;
          mem_span_out <= 17'(fci_pkg::FCI_EE_SECTOR);
        end
      end
      else if (cmd_q == fci_pkg::FCI_CMD_SERA)
        mem_span_out <= 17'(fci_pkg::FCI_FL_SECTOR);
      else if (cmd_q == fci_pkg::FCI_CMD_MERA)
        mem_span_out <= is_eeprom ? 17'h00800 : 17'h0EA80;
    end
  end

endmodule : fci_top

// [verification/fci_top_monitor.sv]
// Purpose: Port checker for the command interface.
// Assumes: Bound into fci_top from tb_top.
// Notes:   Watches design outputs against bus inputs.
`timescale 1ns/1ps
module fci_top_chk (
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        avs_response_err_out,
  input wire logic        mem_en_out,
  input wire logic        mem_eeprom_out,
  input wire logic        mem_erase_out,
  input wire logic [16:0] mem_addr_out,
  input wire logic [16:0] mem_span_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // The answer edge of a bus access.
  sequence ans_s;
    !avs_waitrequest_out && (avs_read_in || avs_write_in);
  endsequence

  // Erase in progress on two consecutive cycles.
  sequence ers_run_s;
    mem_en_out && mem_erase_out && $past(mem_en_out) && $past(mem_erase_out);
  endsequence

  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  wait_cause_a: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
    else $error("answer without request");
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered in one cycle");
  err_unmapped_a: assert property (ans_s ##0 (avs_address_in > 8'h20) |-> avs_response_err_out)
    else $error("unmapped access not flagged");
  err_mapped_a: assert property (ans_s ##0 (avs_address_in <= 8'h20 && avs_address_in[1:0] == 2'b00)
    |-> !avs_response_err_out)
    else $error("mapped access flagged");
  err_zero_a: assert property (ans_s ##0 (avs_read_in && avs_response_err_out) |-> avs_readdata_out == 32'h0)
    else $error("refused read not zero");
  erase_hold_a: assert property (ers_run_s |-> $stable(mem_addr_out) && $stable(mem_span_out))
    else $error("erase target moved");
  flash_span_a: assert property (mem_en_out && mem_erase_out && !mem_eeprom_out
    |-> mem_span_out == 17'd768 || mem_span_out == 17'd60032)
    else $error("flash erase size wrong");
  ee_span_a: assert property (mem_en_out && mem_erase_out && mem_eeprom_out
    |-> mem_span_out inside {17'd4, 17'd8, 17'd1024, 17'd2048})
    else $error("eeprom erase size wrong");
endmodule : fci_top_chk

// [verification/fci_mem_model.sv]
// Purpose: Array model that reports the erased state.
// Assumes: Bench marks the array written through soil_in.
// Notes:   Any erase operation cleans the model.
`timescale 1ns/1ps
module fci_mem_model (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic mem_en_in,
  input  wire logic mem_erase_in,
  input  wire logic soil_in,
  output logic      erased_out
);
  logic dirty_q;

  // Tracks whether the array holds programmed bytes.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      dirty_q <= 1'b0;
    else if (soil_in)
      dirty_q <= 1'b1;
    else if (mem_en_in && mem_erase_in)
      dirty_q <= 1'b0;
  end

  assign erased_out = ~dirty_q;
endmodule : fci_mem_model

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the command interface.
// Assumes: 10 MHz clock, divider loaded with zero.
// Notes:   Erase and blank-check counts are shortened.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ST = fci_pkg::FCI_OFF_STAT;
  localparam logic [7:0] CM = fci_pkg::FCI_OFF_CMD;
  localparam logic [7:0] AD = fci_pkg::FCI_OFF_ADDR;
  localparam logic [7:0] PROG = fci_pkg::FCI_CMD_PROG;
  logic        mclk_in, arst_n_in, rd, wr, soil, e, wt, err, men, mee, mer, ers, l_ers, l_ee;
  logic [7:0]  adr, mdat, l_dat;
  logic [31:0] wd, rdat, q;
  logic [16:0] madr, mspan, l_span, l_adr;
  int          error_cnt, n_compared, en_cyc, p_cyc;

  fci_top #(.ERASE_TICKS(4), .BLANK_WORDS(4)) i_fci_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .avs_response_err_out(err),
    .mem_erased_in(ers), .mem_en_out(men), .mem_eeprom_out(mee), .mem_erase_out(mer), .mem_addr_out(madr),
    .mem_data_out(mdat), .mem_span_out(mspan));
  fci_mem_model i_fci_mem_model (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .mem_en_in(men),
    .mem_erase_in(mer), .soil_in(soil), .erased_out(ers));

  // Clock generator.
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  // Records what the last array operation looked like.
  always @(posedge mclk_in)
    if (men)
    begin
      en_cyc <= en_cyc + 1;
      {l_ers, l_ee, l_span, l_dat, l_adr} <= {mer, mee, mspan, mdat, madr};
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; holds until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    {rd, wr, adr, wd} <= {~w, w, a, d};
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    {q, e} = {rdat, err};
    {rd, wr} <= 2'b00;
    if (n >= 20)
      error_cnt++;
  endtask : bus

  // Issues one command and polls status until bit b is set.
  task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c, input int b);
    int n;
    bus(1'b1, AD, {16'h0, a});
    bus(1'b1, fci_pkg::FCI_OFF_DATA, {24'h0, d});
    bus(1'b1, CM, {24'h0, c});
    bus(1'b1, ST, 32'h80);
    n = 0;
    do
    begin
      bus(1'b0, ST, 32'h0);
      n++;
    end
    while (q[b] !== 1'b1 && n < 60);
    chk(n < 60, 1);
    repeat (3) @(posedge mclk_in);
  endtask : op

  task automatic t_reset();
    bus(1'b0, ST, 32'h0);
    chk(q, 32'hC0);
    bus(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    en_cyc = 0;
    op(16'h1080, 8'h5A, PROG, 6);
    chk(q & 32'h10, 32'h10);
    chk(en_cyc, 0);
    bus(1'b1, ST, 32'h30);
    bus(1'b1, fci_pkg::FCI_OFF_DIV, 32'h0);
    bus(1'b0, fci_pkg::FCI_OFF_DIV, 32'h0);
    chk(q[7], 1);
  endtask : t_reset

  task automatic t_prog();
    en_cyc = 0;
    op(16'h1080, 8'hA5, PROG, 6);
    chk(q, 32'hC0);
    chk({l_span, l_dat}, {17'd1, 8'hA5});
    chk(en_cyc >= 4 && en_cyc <= 8, 1);
    p_cyc = en_cyc;
    en_cyc = 0;
    op(16'h1081, 8'h3C, fci_pkg::FCI_CMD_BURST, 7);
    op(16'h1082, 8'hC3, fci_pkg::FCI_CMD_BURST, 6);
    chk(l_dat, 8'hC3);
    chk(en_cyc < 2 * p_cyc, 1);
  endtask : t_prog

  task automatic t_erase();
    logic [15:0] ea [4] = '{16'h1900, 16'h1900, 16'h0800, 16'h0800};
    logic [16:0] es [4] = '{17'd768, 17'd60032, 17'd8, 17'd2048};
    for (int i = 0; i < 4; i++)
    begin
      op(ea[i], 8'h0, i[0] ? fci_pkg::FCI_CMD_MERA : fci_pkg::FCI_CMD_SERA, 6);
      chk({l_ers, l_ee, l_span}, {1'b1, i[1], es[i]});
    end
    bus(1'b1, fci_pkg::FCI_OFF_CFG, 32'h40);
    op(16'h0805, 8'h77, PROG, 6);
    chk(l_adr, 17'h0000D);
    op(16'h0805, 8'h0, fci_pkg::FCI_CMD_SERA, 6);
    chk(l_adr, 17'h00008);
    bus(1'b1, fci_pkg::FCI_OFF_OPT, 32'h20);
    bus(1'b1, fci_pkg::FCI_OFF_CFG, 32'h40);
    bus(1'b0, fci_pkg::FCI_OFF_CFG, 32'h0);
    chk(q[6], 1);
    op(16'h0808, 8'h0, fci_pkg::FCI_CMD_SERA, 6);
    chk({l_ee, l_span}, {1'b1, 17'd8});
    chk(l_adr, 17'h00408);
  endtask : t_erase

  task automatic t_blank();
    op(16'h1900, 8'h0, fci_pkg::FCI_CMD_BLANK, 6);
    chk(q, 32'hC4);
    soil <= 1'b1;
    @(posedge mclk_in);
    soil <= 1'b0;
    op(16'h1900, 8'h0, fci_pkg::FCI_CMD_BLANK, 6);
    chk(q, 32'hC0);
  endtask : t_blank

  task automatic t_refuse();
    bus(1'b1, AD, 32'h1080);
    bus(1'b1, fci_pkg::FCI_OFF_DATA, 32'h0);
    bus(1'b1, ST, 32'h80);
    bus(1'b0, ST, 32'h0);
    chk(q[4], 1);
    bus(1'b1, ST, 32'h30);
    bus(1'b1, fci_pkg::FCI_OFF_PROT, 32'h01);
    en_cyc = 0;
    op(16'hFFFF, 8'h11, PROG, 6);
    chk(q[5], 1);
    op(16'h1500, 8'h11, PROG, 6);
    chk(en_cyc, 0);
  endtask : t_refuse

  task automatic wrap_up();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial
  begin
    {rd, wr, soil, adr, wd} = '0;
    {error_cnt, n_compared, en_cyc} = '0;
    arst_n_in = 1'b0;
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_prog();
    t_erase();
    t_blank();
    t_refuse();
    wrap_up();
  end

  // Watchdog cuts a hang short.
  initial
  begin
    #(100 * 20000);
    error_cnt++;
    wrap_up();
  end
endmodule : tb_top

bind fci_top fci_top_chk i_fci_top_chk (.*);
